// *** rtc_pkg.sv ***
// Constants and types of the clock and calendar core
package rtc_pkg;
  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [3:0] RTC_SEC     = 4'h0;
  localparam logic [3:0] RTC_MIN     = 4'h1;
  localparam logic [3:0] RTC_HOUR    = 4'h2;
  localparam logic [3:0] RTC_WDAY    = 4'h3;
  localparam logic [3:0] RTC_MDAY    = 4'h4;
  localparam logic [3:0] RTC_MONTH   = 4'h5;
  localparam logic [3:0] RTC_YEAR    = 4'h6;
  localparam logic [3:0] RTC_TRIM    = 4'h7;
  localparam logic [3:0] RTC_WA_MIN  = 4'h8;
  localparam logic [3:0] RTC_WA_HOUR = 4'h9;
  localparam logic [3:0] RTC_WA_DAYS = 4'ha;
  localparam logic [3:0] RTC_DA_MIN  = 4'hb;
  localparam logic [3:0] RTC_DA_HOUR = 4'hc;
  localparam logic [3:0] RTC_CTL1    = 4'he;
  localparam logic [3:0] RTC_CTL2    = 4'hf;
  // Implemented bits per register, index 15 first
  localparam logic [15:0][7:0] RTC_WMASK = {
    8'hff, 8'hff, 8'h00, 8'h3f, 8'h7f, 8'h7f, 8'h3f, 8'h7f,
    8'h7f, 8'hff, 8'h9f, 8'h3f, 8'h07, 8'h3f, 8'h7f, 8'h7f};
  // ****************************************
  // Field positions
  // ****************************************
  localparam int RTC_C1_WEEKLY_ALARM_ENABLE = 7;
  localparam int RTC_C1_DAILY_ALARM_ENABLE = 6;
  localparam int RTC_C1_H24  = 5;
  localparam int RTC_C1_DISA = 4;
  localparam int RTC_C2_SUPPLY_THRESHOLD_SELECT = 7;
  localparam int RTC_C2_SUPPLY_LOW_FLAG = 6;
  localparam int RTC_C2_XST  = 5;
  localparam int RTC_C2_PON  = 4;
  localparam int RTC_C2_DISB = 3;
  localparam int RTC_C2_PERIODIC_FLAG = 2;
  localparam int RTC_C2_WEEKLY_ALARM_FLAG = 1;
  localparam int RTC_C2_DAILY_ALARM_FLAG = 0;
  localparam int RTC_HR_PM   = 5;
  localparam int RTC_MO_CENT = 7;
  localparam logic [7:0] RTC_FLAG_BITS = 8'h47;
  // Power-on value of the second control register
  localparam logic [7:0] RTC_CTL2_RST  = 8'h10;
  // Periodic select codes
  localparam logic [2:0] RTC_PI_LOW  = 3'h1;
  localparam logic [2:0] RTC_PI_2HZ  = 3'h2;
  localparam logic [2:0] RTC_PI_1HZ  = 3'h3;
  localparam logic [2:0] RTC_PI_SEC  = 3'h4;
  localparam logic [2:0] RTC_PI_MIN  = 3'h5;
  localparam logic [2:0] RTC_PI_HOUR = 3'h6;
  localparam logic [2:0] RTC_PI_MON  = 3'h7;
  // ****************************************
  // Timing
  // ****************************************
  localparam int RTC_CLK_PERIOD_NS = 10;
  localparam int RTC_OSC_HZ        = 32768;
  localparam int RTC_HALT_TIME_NS  = 100000;
  localparam int RTC_HALT_CYCLES   = RTC_HALT_TIME_NS / RTC_CLK_PERIOD_NS;
  localparam int RTC_SCL_MAX_KHZ   = 400;
  localparam logic [6:0] RTC_DEV_ADDR = 7'h50;
  typedef enum logic [4:0] {
    RTC_IDLE  = 5'h01,
    RTC_RX    = 5'h02,
    RTC_RXACK = 5'h04,
    RTC_TX    = 5'h08,
    RTC_TXACK = 5'h10
  } rtc_state_t;
endpackage

// *** rtc_core.sv ***
// Serial clock and calendar core with alarms and periodic interrupt
`timescale 1ns/10ps
module rtc_core #(
  parameter logic [6:0] DEV_ADDR    = rtc_pkg::RTC_DEV_ADDR,
  parameter int         OSC_HZ      = rtc_pkg::RTC_OSC_HZ,
  parameter int         HALT_CYCLES = rtc_pkg::RTC_HALT_CYCLES
) (
  // System clock and reset
  input  wire logic MCLK,
  input  wire logic SYS_RST,
  // Oscillator clock
  input  wire logic OSC_CLK,
  // Serial bus
  input  wire logic SCL_I,
  input  wire logic SDA_I,
  output logic      SDA_O,
  output logic      SDA_OE,
  // Interrupt pins, open drain
  output logic      IRQ_OUT_A_O,
  output logic      IRQ_OUT_A_OE,
  output logic      IRQ_OUT_B_O,
  output logic      IRQ_OUT_B_OE,
  // Clock output
  input  wire logic CLKOUT_ENABLE_PIN,
  output logic      SLOW_CLOCK_OUT,
  // Supply comparators, high when the supply is below that threshold
  input  wire logic SUPPLY_BELOW_HIGH,
  input  wire logic SUPPLY_BELOW_LOW
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    rtc_pkg::rtc_state_t st;
    logic [2:0]          cnt;
    logic [7:0]          sh;
    logic [1:0]          ph;
    logic                rw;
    logic                done;
    logic                more;
    logic [3:0]          ptr;
    logic                sda_oe;
    logic [2:0]          scl_s;
    logic [2:0]          sda_s;
    logic [2:0]          tk_s;
    logic [1:0]          clkout_enable_pin_s;
    logic [1:0]          bhi_s;
    logic [1:0]          blo_s;
    logic [15:0]         sub;
    logic [15:0]         halt;
    logic [15:0][7:0]    regs;
    logic                clk_en;
    logic                irq_a;
    logic                irq_b;
  } rtc_main_t;

  typedef struct packed {
    logic [1:0] rst_s;
    logic       tgl;
    logic [1:0] en_s;
  } rtc_osc_t;

  localparam logic [15:0] TERM  = 16'(OSC_HZ - 1);
  localparam logic [15:0] HALF  = 16'(OSC_HZ / 2);
  localparam logic [15:0] QTR   = 16'(OSC_HZ / 4);
  localparam logic [15:0] HLIM  = 16'(HALT_CYCLES);
  // Local copies of the package constants used below
  localparam logic [3:0] RTC_SEC     = rtc_pkg::RTC_SEC;
  localparam logic [3:0] RTC_MIN     = rtc_pkg::RTC_MIN;
  localparam logic [3:0] RTC_HOUR    = rtc_pkg::RTC_HOUR;
  localparam logic [3:0] RTC_WDAY    = rtc_pkg::RTC_WDAY;
  localparam logic [3:0] RTC_MDAY    = rtc_pkg::RTC_MDAY;
  localparam logic [3:0] RTC_MONTH   = rtc_pkg::RTC_MONTH;
  localparam logic [3:0] RTC_YEAR    = rtc_pkg::RTC_YEAR;
  localparam logic [3:0] RTC_TRIM    = rtc_pkg::RTC_TRIM;
  localparam logic [3:0] RTC_WA_MIN  = rtc_pkg::RTC_WA_MIN;
  localparam logic [3:0] RTC_WA_HOUR = rtc_pkg::RTC_WA_HOUR;
  localparam logic [3:0] RTC_WA_DAYS = rtc_pkg::RTC_WA_DAYS;
  localparam logic [3:0] RTC_DA_MIN  = rtc_pkg::RTC_DA_MIN;
  localparam logic [3:0] RTC_DA_HOUR = rtc_pkg::RTC_DA_HOUR;
  localparam logic [3:0] RTC_CTL1    = rtc_pkg::RTC_CTL1;
  localparam logic [3:0] RTC_CTL2    = rtc_pkg::RTC_CTL2;
  localparam logic [15:0][7:0] RTC_WMASK = rtc_pkg::RTC_WMASK;
  localparam int RTC_C1_WEEKLY_ALARM_ENABLE = rtc_pkg::RTC_C1_WEEKLY_ALARM_ENABLE;
  localparam int RTC_C1_DAILY_ALARM_ENABLE = rtc_pkg::RTC_C1_DAILY_ALARM_ENABLE;
  localparam int RTC_C1_H24  = rtc_pkg::RTC_C1_H24;
  localparam int RTC_C1_DISA = rtc_pkg::RTC_C1_DISA;
  localparam int RTC_C2_SUPPLY_THRESHOLD_SELECT = rtc_pkg::RTC_C2_SUPPLY_THRESHOLD_SELECT;
  localparam int RTC_C2_SUPPLY_LOW_FLAG = rtc_pkg::RTC_C2_SUPPLY_LOW_FLAG;
  localparam int RTC_C2_XST  = rtc_pkg::RTC_C2_XST;
  localparam int RTC_C2_PON  = rtc_pkg::RTC_C2_PON;
  localparam int RTC_C2_DISB = rtc_pkg::RTC_C2_DISB;
  localparam int RTC_C2_PERIODIC_FLAG = rtc_pkg::RTC_C2_PERIODIC_FLAG;
  localparam int RTC_C2_WEEKLY_ALARM_FLAG = rtc_pkg::RTC_C2_WEEKLY_ALARM_FLAG;
  localparam int RTC_C2_DAILY_ALARM_FLAG = rtc_pkg::RTC_C2_DAILY_ALARM_FLAG;
  localparam int RTC_HR_PM   = rtc_pkg::RTC_HR_PM;
  localparam int RTC_MO_CENT = rtc_pkg::RTC_MO_CENT;
  localparam logic [7:0] RTC_FLAG_BITS = rtc_pkg::RTC_FLAG_BITS;
  localparam logic [7:0] RTC_CTL2_RST  = rtc_pkg::RTC_CTL2_RST;
  localparam logic [2:0] RTC_PI_LOW  = rtc_pkg::RTC_PI_LOW;
  localparam logic [2:0] RTC_PI_2HZ  = rtc_pkg::RTC_PI_2HZ;
  localparam logic [2:0] RTC_PI_1HZ  = rtc_pkg::RTC_PI_1HZ;
  localparam logic [2:0] RTC_PI_SEC  = rtc_pkg::RTC_PI_SEC;
  localparam logic [2:0] RTC_PI_MIN  = rtc_pkg::RTC_PI_MIN;
  localparam logic [2:0] RTC_PI_HOUR = rtc_pkg::RTC_PI_HOUR;
  localparam logic [2:0] RTC_PI_MON  = rtc_pkg::RTC_PI_MON;
  localparam rtc_pkg::rtc_state_t RTC_IDLE  = rtc_pkg::RTC_IDLE;
  localparam rtc_pkg::rtc_state_t RTC_RX    = rtc_pkg::RTC_RX;
  localparam rtc_pkg::rtc_state_t RTC_RXACK = rtc_pkg::RTC_RXACK;
  localparam rtc_pkg::rtc_state_t RTC_TX    = rtc_pkg::RTC_TX;
  localparam rtc_pkg::rtc_state_t RTC_TXACK = rtc_pkg::RTC_TXACK;

  rtc_main_t q_q, q_d;
  rtc_osc_t  o_q, o_d;

  // ****************************************
  // BCD helpers
  // ****************************************
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic logic [7:0] last_day(input logic [4:0] mo, input logic [7:0] y);
    logic leap;
    leap = (!y[4] && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)) ||
           (y[4] && (y[3:0] == 4'h2 || y[3:0] == 4'h6));
    if (mo == 5'h02) begin
      last_day = leap ? 8'h29 : 8'h28;
    end else if (mo == 5'h04 || mo == 5'h06 || mo == 5'h09 || mo == 5'h11) begin
      last_day = 8'h30;
    end else begin
      last_day = 8'h31;
    end
  endfunction

  // ****************************************
  // Oscillator domain
  // ****************************************
  always_comb begin
    o_d       = o_q;
    o_d.rst_s = {o_q.rst_s[0], SYS_RST};
    o_d.en_s  = {o_q.en_s[0], q_q.clk_en};
    o_d.tgl   = ~o_q.tgl;
    if (o_q.rst_s[1]) begin
      o_d.tgl  = 1'b0;
      o_d.en_s = 2'b00;
    end
  end

  always_ff @(posedge OSC_CLK) begin
    o_q <= o_d;
  end

  assign SLOW_CLOCK_OUT = OSC_CLK & o_q.en_s[1];

  // ****************************************
  // System domain
  // ****************************************
  logic              tick, rise, fall, start, stop, sda_v;
  logic              sec_evt, min_evt, hr_evt, mon_evt;
  logic              set_ct, set_wa, set_da, set_vd, halted;
  logic              h24, pm, p_low;
  logic [7:0]        hv, wd, b;
  logic [2:0]        sel;
  logic signed [17:0] term;

  always_comb begin
    q_d     = q_q;
    sec_evt = 1'b0;
    min_evt = 1'b0;
    hr_evt  = 1'b0;
    mon_evt = 1'b0;
    set_ct  = 1'b0;
    set_wa  = 1'b0;
    set_da  = 1'b0;
    b       = q_q.sh;
    wd      = 8'h00;
    hv      = 8'h00;
    pm      = 1'b0;
    // Pin and crossing synchronisers
    q_d.scl_s  = {q_q.scl_s[1:0], SCL_I};
    q_d.sda_s  = {q_q.sda_s[1:0], SDA_I};
    q_d.tk_s   = {q_q.tk_s[1:0], o_q.tgl};
    q_d.clkout_enable_pin_s = {q_q.clkout_enable_pin_s[0], CLKOUT_ENABLE_PIN};
    q_d.bhi_s  = {q_q.bhi_s[0], SUPPLY_BELOW_HIGH};
    q_d.blo_s  = {q_q.blo_s[0], SUPPLY_BELOW_LOW};
    tick  = q_q.tk_s[1] ^ q_q.tk_s[2];
    sda_v = q_q.sda_s[1];
    rise  = q_q.scl_s[1] & ~q_q.scl_s[2];
    fall  = ~q_q.scl_s[1] & q_q.scl_s[2];
    start = q_q.scl_s[1] & q_q.scl_s[2] & q_q.sda_s[2] & ~sda_v;
    stop  = q_q.scl_s[1] & q_q.scl_s[2] & ~q_q.sda_s[2] & sda_v;
    // Oscillator halt watchdog
    halted = 1'b0;
    if (tick) begin
      q_d.halt = 16'h0000;
    end else if (q_q.halt >= HLIM) begin
      halted = 1'b1;
    end else begin
      q_d.halt = q_q.halt + 16'h0001;
    end
    // Sub-second divider, trimmed every twenty seconds
    term = $signed({2'b00, TERM});
    if (q_q.regs[RTC_SEC][3:0] == 4'h0 && !q_q.regs[RTC_SEC][4]) begin
      term = term - ($signed({{11{q_q.regs[RTC_TRIM][6]}}, q_q.regs[RTC_TRIM][6:0]}) <<< 1);
    end
    if (tick) begin
      if (q_q.sub >= term[15:0]) begin
        q_d.sub = 16'h0000;
        sec_evt = 1'b1;
      end else begin
        q_d.sub = q_q.sub + 16'h0001;
      end
    end
    // Time and calendar chain
    h24 = q_q.regs[RTC_CTL1][RTC_C1_H24];
    if (sec_evt) begin
      q_d.regs[RTC_SEC] = bcd_inc(q_q.regs[RTC_SEC]);
      if (q_q.regs[RTC_SEC] == 8'h59) begin
        q_d.regs[RTC_SEC] = 8'h00;
        min_evt = 1'b1;
        q_d.regs[RTC_MIN] = bcd_inc(q_q.regs[RTC_MIN]);
        if (q_q.regs[RTC_MIN] == 8'h59) begin
          q_d.regs[RTC_MIN] = 8'h00;
          hr_evt = 1'b1;
        end
      end
    end
    if (hr_evt) begin
      hv = q_q.regs[RTC_HOUR];
      pm = hv[RTC_HR_PM];
      if (h24) begin
        q_d.regs[RTC_HOUR] = (hv == 8'h23) ? 8'h00 : bcd_inc(hv);
      end else if (hv[4:0] == 5'h12) begin
        q_d.regs[RTC_HOUR] = {2'b00, pm, 5'h01};
      end else if (hv[4:0] == 5'h11) begin
        q_d.regs[RTC_HOUR] = {2'b00, ~pm, 5'h12};
      end else begin
        q_d.regs[RTC_HOUR] = {2'b00, pm, 5'(bcd_inc({3'b000, hv[4:0]}))};
      end
      if ((h24 && hv == 8'h23) || (!h24 && pm && hv[4:0] == 5'h11)) begin
        q_d.regs[RTC_WDAY] = (q_q.regs[RTC_WDAY] == 8'h06) ? 8'h00 : q_q.regs[RTC_WDAY] + 8'h01;
        q_d.regs[RTC_MDAY] = bcd_inc(q_q.regs[RTC_MDAY]);
        if (q_q.regs[RTC_MDAY] == last_day(q_q.regs[RTC_MONTH][4:0], q_q.regs[RTC_YEAR])) begin
          q_d.regs[RTC_MDAY] = 8'h01;
          mon_evt = 1'b1;
          q_d.regs[RTC_MONTH][4:0] = 5'(bcd_inc({3'b000, q_q.regs[RTC_MONTH][4:0]}));
          if (q_q.regs[RTC_MONTH][4:0] == 5'h12) begin
            q_d.regs[RTC_MONTH][4:0] = 5'h01;
            q_d.regs[RTC_YEAR] = bcd_inc(q_q.regs[RTC_YEAR]);
            if (q_q.regs[RTC_YEAR] == 8'h99) begin
              q_d.regs[RTC_YEAR] = 8'h00;
              q_d.regs[RTC_MONTH][RTC_MO_CENT] = ~q_q.regs[RTC_MONTH][RTC_MO_CENT];
            end
          end
        end
      end
    end
    // Alarm compare on each new minute
    if (min_evt) begin
      set_da = q_q.regs[RTC_CTL1][RTC_C1_DAILY_ALARM_ENABLE] &&
               q_d.regs[RTC_MIN] == q_q.regs[RTC_DA_MIN] &&
               q_d.regs[RTC_HOUR] == q_q.regs[RTC_DA_HOUR];
      set_wa = q_q.regs[RTC_CTL1][RTC_C1_WEEKLY_ALARM_ENABLE] &&
               q_d.regs[RTC_MIN] == q_q.regs[RTC_WA_MIN] &&
               q_d.regs[RTC_HOUR] == q_q.regs[RTC_WA_HOUR] &&
               q_q.regs[RTC_WA_DAYS][q_d.regs[RTC_WDAY][2:0]];
    end
    // Periodic level events
    sel = q_q.regs[RTC_CTL1][2:0];
    if (sel == RTC_PI_SEC) begin
      set_ct = sec_evt;
    end else if (sel == RTC_PI_MIN) begin
      set_ct = min_evt;
    end else if (sel == RTC_PI_HOUR) begin
      set_ct = hr_evt;
    end else if (sel == RTC_PI_MON) begin
      set_ct = mon_evt;
    end
    set_vd = q_q.regs[RTC_CTL2][RTC_C2_SUPPLY_THRESHOLD_SELECT] ? q_q.blo_s[1] : q_q.bhi_s[1];
    // Serial slave
    if (start) begin
      q_d.st     = RTC_RX;
      q_d.cnt    = 3'h0;
      q_d.ph     = 2'h0;
      q_d.done   = 1'b0;
      q_d.sda_oe = 1'b0;
    end else if (stop) begin
      q_d.st     = RTC_IDLE;
      q_d.sda_oe = 1'b0;
    end else begin
      case (q_q.st)
        RTC_RX: begin
          if (rise) begin
            q_d.sh  = {q_q.sh[6:0], sda_v};
            q_d.cnt = q_q.cnt + 3'h1;
            q_d.done = (q_q.cnt == 3'h7);
          end else if (fall && q_q.done) begin
            q_d.done   = 1'b0;
            q_d.sda_oe = 1'b1;
            q_d.st     = RTC_RXACK;
            if (q_q.ph == 2'h0) begin
              q_d.rw = b[0];
              if (b[7:1] != DEV_ADDR) begin
                q_d.sda_oe = 1'b0;
                q_d.st     = RTC_IDLE;
              end
            end else if (q_q.ph == 2'h1) begin
              q_d.ptr = b[3:0];
            end else begin
              wd = b & RTC_WMASK[q_q.ptr];
              q_d.regs[q_q.ptr] = wd;
              if (q_q.ptr == RTC_CTL2) begin
                q_d.regs[RTC_CTL2] = (wd & ~RTC_FLAG_BITS) | (wd & q_q.regs[RTC_CTL2] & RTC_FLAG_BITS);
              end
              if (q_q.ptr == RTC_SEC) begin
                q_d.sub = 16'h0000;
              end
              q_d.ptr = q_q.ptr + 4'h1;
            end
          end
        end
        RTC_RXACK: begin
          if (fall) begin
            q_d.sda_oe = 1'b0;
            q_d.st     = RTC_RX;
            q_d.cnt    = 3'h0;
            q_d.ph     = (q_q.ph == 2'h0) ? 2'h1 : 2'h2;
            if (q_q.ph == 2'h0 && q_q.rw) begin
              q_d.sh     = q_q.regs[q_q.ptr];
              q_d.sda_oe = ~q_q.regs[q_q.ptr][7];
              q_d.st     = RTC_TX;
            end
          end
        end
        RTC_TX: begin
          if (fall) begin
            if (q_q.cnt == 3'h7) begin
              q_d.sda_oe = 1'b0;
              q_d.st     = RTC_TXACK;
              q_d.ptr    = q_q.ptr + 4'h1;
            end else begin
              q_d.sh     = {q_q.sh[6:0], 1'b0};
              q_d.sda_oe = ~q_q.sh[6];
              q_d.cnt    = q_q.cnt + 3'h1;
            end
          end
        end
        RTC_TXACK: begin
          if (rise) begin
            q_d.more = ~sda_v;
          end else if (fall) begin
            q_d.st = RTC_IDLE;
            if (q_q.more) begin
              q_d.sh     = q_q.regs[q_q.ptr];
              q_d.sda_oe = ~q_q.regs[q_q.ptr][7];
              q_d.cnt    = 3'h0;
              q_d.st     = RTC_TX;
            end
          end
        end
        default: begin
          q_d.sda_oe = 1'b0;
        end
      endcase
    end
    // Sticky flags; hardware set wins over host clear
    if (set_da) begin
      q_d.regs[RTC_CTL2][RTC_C2_DAILY_ALARM_FLAG] = 1'b1;
    end
    if (set_wa) begin
      q_d.regs[RTC_CTL2][RTC_C2_WEEKLY_ALARM_FLAG] = 1'b1;
    end
    if (set_ct) begin
      q_d.regs[RTC_CTL2][RTC_C2_PERIODIC_FLAG] = 1'b1;
    end
    if (set_vd) begin
      q_d.regs[RTC_CTL2][RTC_C2_SUPPLY_LOW_FLAG] = 1'b1;
    end
    if (halted) begin
      q_d.regs[RTC_CTL2][RTC_C2_XST] = 1'b0;
    end
    if (!q_d.regs[RTC_CTL1][RTC_C1_DAILY_ALARM_ENABLE]) begin
      q_d.regs[RTC_CTL2][RTC_C2_DAILY_ALARM_FLAG] = 1'b0;
    end
    if (!q_d.regs[RTC_CTL1][RTC_C1_WEEKLY_ALARM_ENABLE]) begin
      q_d.regs[RTC_CTL2][RTC_C2_WEEKLY_ALARM_FLAG] = 1'b0;
    end
    // Power-on hold clears trim and controls
    if (q_d.regs[RTC_CTL2][RTC_C2_PON]) begin
      q_d.regs[RTC_TRIM] = 8'h00;
      q_d.regs[RTC_CTL1] = 8'h00;
      q_d.regs[RTC_CTL2] = q_d.regs[RTC_CTL2] & (8'h01 << RTC_C2_XST | 8'h01 << RTC_C2_PON);
    end
    // Periodic waveform and pin drive
    sel   = q_d.regs[RTC_CTL1][2:0];
    p_low = 1'b0;
    if (sel == RTC_PI_LOW) begin
      p_low = 1'b1;
    end else if (sel == RTC_PI_1HZ) begin
      p_low = q_d.sub < HALF;
    end else if (sel == RTC_PI_2HZ) begin
      p_low = q_d.sub < QTR || (q_d.sub >= HALF && q_d.sub < HALF + QTR);
    end else if (sel[2]) begin
      p_low = q_d.regs[RTC_CTL2][RTC_C2_PERIODIC_FLAG];
    end
    if (!sel[2]) begin
      q_d.regs[RTC_CTL2][RTC_C2_PERIODIC_FLAG] = p_low;
    end
    q_d.irq_a = p_low | q_d.regs[RTC_CTL2][RTC_C2_DAILY_ALARM_FLAG];
    q_d.irq_b = q_d.regs[RTC_CTL2][RTC_C2_WEEKLY_ALARM_FLAG];
    q_d.clk_en = q_q.clkout_enable_pin_s[1] &
                 ~(q_d.regs[RTC_CTL1][RTC_C1_DISA] & q_d.regs[RTC_CTL2][RTC_C2_DISB]);
    if (SYS_RST) begin
      q_d        = '0;
      q_d.st     = RTC_IDLE;
      q_d.scl_s  = 3'h7;
      q_d.sda_s  = 3'h7;
      q_d.regs[RTC_MDAY]  = 8'h01;
      q_d.regs[RTC_MONTH] = 8'h01;
      q_d.regs[RTC_CTL2]  = RTC_CTL2_RST;
    end
  end

  always_ff @(posedge MCLK) begin
    q_q <= q_d;
  end

  // ****************************************
  // Pins
  // ****************************************
  assign SDA_O        = 1'b0;
  assign SDA_OE       = q_q.sda_oe;
  assign IRQ_OUT_A_O  = 1'b0;
  assign IRQ_OUT_A_OE = q_q.irq_a;
  assign IRQ_OUT_B_O  = 1'b0;
  assign IRQ_OUT_B_OE = q_q.irq_b;
endmodule

// *** rtc_core_asserts.sv ***
// Pin-level checks of the clock and calendar core
`timescale 1ns/10ps
module rtc_core_asserts (
  // Clocks and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic OSC_CLK,
  // Serial bus
  input wire logic SCL_I,
  input wire logic SDA_O,
  input wire logic SDA_OE,
  // Interrupt pins
  input wire logic IRQ_OUT_A_O,
  input wire logic IRQ_OUT_A_OE,
  input wire logic IRQ_OUT_B_O,
  input wire logic IRQ_OUT_B_OE,
  // Clock output
  input wire logic CLKOUT_ENABLE_PIN,
  input wire logic SLOW_CLOCK_OUT
);
  // Cycles the enable pin has been low, saturating
  logic [4:0] pin_lo_q;
  always_ff @(posedge MCLK) begin
    if (SYS_RST || CLKOUT_ENABLE_PIN) begin
      pin_lo_q <= 5'h00;
    end else if (pin_lo_q != 5'h1f) begin
      pin_lo_q <= pin_lo_q + 5'h01;
    end
  end
  property p_sda_low_only;
    @(posedge MCLK) disable iff (SYS_RST) SDA_O == 1'b0;
  endproperty
  a_sda_low_only: assert property (p_sda_low_only)
    else $error("data pin driven high");
  property p_irq_low_only;
    @(posedge MCLK) disable iff (SYS_RST) IRQ_OUT_A_O == 1'b0 && IRQ_OUT_B_O == 1'b0;
  endproperty
  a_irq_low_only: assert property (p_irq_low_only)
    else $error("interrupt pin driven high");
  property p_boot_quiet;
    @(posedge MCLK) disable iff (SYS_RST)
      $fell(SYS_RST) |-> (!SDA_OE && !IRQ_OUT_A_OE && !IRQ_OUT_B_OE) [*8];
  endproperty
  a_boot_quiet: assert property (p_boot_quiet)
    else $error("pin pulled low right after reset");
  property p_turn_at_low;
    @(posedge MCLK) disable iff (SYS_RST)
      $changed(SDA_OE) |-> !SCL_I && $past(SCL_I, 2) == 1'b0;
  endproperty
  a_turn_at_low: assert property (p_turn_at_low)
    else $error("data drive changed outside clock low");
  property p_hold_while_high;
    @(posedge MCLK) disable iff (SYS_RST) SCL_I [*6] |-> $stable(SDA_OE);
  endproperty
  a_hold_while_high: assert property (p_hold_while_high)
    else $error("data drive changed while clock high");
  property p_bit_stands;
    @(posedge MCLK) disable iff (SYS_RST) $rose(SDA_OE) |-> SDA_OE [*8];
  endproperty
  a_bit_stands: assert property (p_bit_stands)
    else $error("driven bit released too early");
  property p_clkout_gated;
    @(posedge MCLK) disable iff (SYS_RST) pin_lo_q > 5'h14 |-> !SLOW_CLOCK_OUT;
  endproperty
  a_clkout_gated: assert property (p_clkout_gated)
    else $error("clock output runs with enable pin low");
  property p_clkout_from_osc;
    @(posedge MCLK) disable iff (SYS_RST) SLOW_CLOCK_OUT |-> OSC_CLK;
  endproperty
  a_clkout_from_osc: assert property (p_clkout_from_osc)
    else $error("clock output high while oscillator low");
endmodule

// *** rtc_host.sv ***
// Behavioural serial bus host for the clock and calendar core
`timescale 1ns/10ps
module rtc_host #(
  parameter logic [6:0] ADDR = 7'h00
) (
  // Clock
  input  wire logic clk,
  // Serial pins
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull,
  // Missing acknowledges seen
  output int        nacks
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
    nacks = 0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One bit: 130 cycles low, 120 high
  task automatic xbit(input logic b, output logic r);
    hold(10);
    sda_pull <= ~b;
    hold(120);
    scl <= 1'b1;
    hold(60);
    r = sda;
    hold(60);
    scl <= 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic rel, input logic chk,
                       output logic [7:0] q);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(rel, a);
    if (chk && a !== 1'b0) begin
      nacks++;
    end
  endtask
  // Serves as start and repeated start
  task automatic start();
    sda_pull <= 1'b0;
    hold(60);
    scl <= 1'b1;
    hold(60);
    sda_pull <= 1'b1;
    hold(60);
    scl <= 1'b0;
  endtask
  task automatic stop();
    hold(10);
    sda_pull <= 1'b1;
    hold(120);
    scl <= 1'b1;
    hold(60);
    sda_pull <= 1'b0;
    hold(130);
  endtask
  task automatic wr(input logic [3:0] ptr, input logic [7:0] d[$]);
    logic [7:0] q;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, 1'b1, q);
    xbyte({4'h0, ptr}, 1'b1, 1'b1, q);
    foreach (d[i]) begin
      xbyte(d[i], 1'b1, 1'b1, q);
    end
    stop();
  endtask
  task automatic rd(input logic [3:0] ptr, input int n, output logic [7:0] d[$]);
    logic [7:0] q;
    d = {};
    start();
    xbyte({ADDR, 1'b0}, 1'b1, 1'b1, q);
    xbyte({4'h0, ptr}, 1'b1, 1'b1, q);
    start();
    xbyte({ADDR, 1'b1}, 1'b1, 1'b1, q);
    for (int i = 0; i < n; i++) begin
      xbyte(8'hff, i == n - 1, 1'b0, q);
      d.push_back(q);
    end
    stop();
  endtask
endmodule

// *** rtc_core_tb.sv ***
// Self-checking testbench of the clock and calendar core
`timescale 1ns/10ps
module rtc_core_tb;
  logic       mclk;
  logic       sys_rst;
  logic       osc_clk;
  logic       clk_en;
  logic       sup_hi;
  logic       sup_lo;
  logic       scl;
  logic       host_pull;
  logic       sda_oe;
  logic       irq_a_oe;
  logic       irq_b_oe;
  logic       slow_clk;
  wire        sda;
  int         host_nacks;
  int         n_fail;
  int         num_checks;
  logic [7:0] rq[$];
  // Wired-and data line with pull-up
  assign sda = ~(host_pull | sda_oe);
  rtc_core #(
    .DEV_ADDR    (rtc_pkg::RTC_DEV_ADDR),
    .OSC_HZ      (8),
    .HALT_CYCLES (64)
  ) u_rtc_core (
    .MCLK              (mclk),
    .SYS_RST           (sys_rst),
    .OSC_CLK           (osc_clk),
    .SCL_I             (scl),
    .SDA_I             (sda),
    .SDA_O             (),
    .SDA_OE            (sda_oe),
    .IRQ_OUT_A_O       (),
    .IRQ_OUT_A_OE      (irq_a_oe),
    .IRQ_OUT_B_O       (),
    .IRQ_OUT_B_OE      (irq_b_oe),
    .CLKOUT_ENABLE_PIN (clk_en),
    .SLOW_CLOCK_OUT    (slow_clk),
    .SUPPLY_BELOW_HIGH (sup_hi),
    .SUPPLY_BELOW_LOW  (sup_lo)
  );
  rtc_host #(.ADDR(rtc_pkg::RTC_DEV_ADDR)) u_rtc_host (
    .clk      (mclk),
    .sda      (sda),
    .scl      (scl),
    .sda_pull (host_pull),
    .nacks    (host_nacks)
  );
  // ****
  // Clocks and helpers
  // ****
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    osc_clk = 1'b0;
    #7;
    forever #15 osc_clk = ~osc_clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic flag(input logic ok, input string what);
    check({7'h00, ok}, 8'h01, what);
  endtask
  // Counts changes of clock output and pin A over n cycles
  task automatic watch(input int n, output int ec, output int ei);
    logic pc;
    logic pi;
    ec = 0;
    ei = 0;
    pc = slow_clk;
    pi = irq_a_oe;
    repeat (n) begin
      @(negedge mclk);
      if (slow_clk !== pc) ec++;
      if (irq_a_oe !== pi) ei++;
      pc = slow_clk;
      pi = irq_a_oe;
    end
    @(posedge mclk);
  endtask
  // ****
  // Scenarios
  // ****
  task automatic t_regs();
    u_rtc_host.rd(4'he, 2, rq);
    check(rq[0], 8'h00, "control one at power on");
    check(rq[1], 8'h10, "control two at power on");
    u_rtc_host.wr(4'hc, '{8'hff, 8'hff, 8'h10, 8'h20});
    u_rtc_host.rd(4'hc, 4, rq);
    check(rq[0], 8'h3f, "alarm hour bits");
    check(rq[1], 8'h00, "unused slot");
    check(rq[2], 8'h00, "control one held clear");
    check(rq[3], 8'h20, "power-on flag cleared");
    $display("t_regs done");
  endtask
  task automatic t_clkout();
    int ec;
    int ei;
    watch(60, ec, ei);
    flag(ec == 0, "clock out with pin low");
    clk_en <= 1'b1;
    watch(20, ec, ei);
    watch(60, ec, ei);
    flag(ec > 0, "clock out with pin high");
    u_rtc_host.wr(4'he, '{8'h10, 8'h28});
    watch(60, ec, ei);
    flag(ec == 0, "both disable bits set");
    sup_lo <= 1'b1;
    watch(10, ec, ei);
    sup_lo <= 1'b0;
    u_rtc_host.rd(4'hf, 1, rq);
    check(rq[0], 8'h28, "low threshold not selected");
    sup_hi <= 1'b1;
    watch(10, ec, ei);
    sup_hi <= 1'b0;
    u_rtc_host.wr(4'he, '{8'h04});
    watch(60, ec, ei);
    flag(ec > 0, "one disable bit clear");
    $display("t_clkout done");
  endtask
  task automatic t_periodic();
    int ec;
    int ei;
    int k;
    k = 0;
    while (irq_a_oe !== 1'b1 && k < 100) begin
      @(negedge mclk);
      k++;
    end
    flag(k < 100, "level interrupt per second");
    if (k == 100) begin
      end_of_test();
    end
    u_rtc_host.rd(4'hf, 1, rq);
    check(rq[0] & 8'h44, 8'h44, "periodic and supply flags");
    u_rtc_host.wr(4'he, '{8'h03});
    watch(240, ec, ei);
    flag(ei >= 18 && ei <= 22, "one hertz wave");
    u_rtc_host.wr(4'he, '{8'h02});
    watch(240, ec, ei);
    flag(ei >= 36 && ei <= 44, "two hertz wave");
    u_rtc_host.wr(4'he, '{8'h01});
    watch(100, ec, ei);
    flag(ei == 0 && irq_a_oe === 1'b1, "pin fixed low");
    flag(irq_b_oe === 1'b0, "pin b idle");
    $display("t_periodic done");
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b0;
    sup_hi = 1'b0;
    sup_lo = 1'b0;
    n_fail = 0;
    num_checks = 0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (5) @(posedge mclk);
    t_regs();
    t_clkout();
    t_periodic();
    flag(host_nacks == 0, "device acknowledges");
    end_of_test();
  end
  initial begin
    repeat (110000) @(posedge mclk);
    n_fail++;
    $display("[FAIL] %0t run too long", $time);
    end_of_test();
  end
endmodule
bind rtc_core rtc_core_asserts u_rtc_core_asserts (
  .MCLK              (MCLK),
  .SYS_RST           (SYS_RST),
  .OSC_CLK           (OSC_CLK),
  .SCL_I             (SCL_I),
  .SDA_O             (SDA_O),
  .SDA_OE            (SDA_OE),
  .IRQ_OUT_A_O       (IRQ_OUT_A_O),
  .IRQ_OUT_A_OE      (IRQ_OUT_A_OE),
  .IRQ_OUT_B_O       (IRQ_OUT_B_O),
  .IRQ_OUT_B_OE      (IRQ_OUT_B_OE),
  .CLKOUT_ENABLE_PIN (CLKOUT_ENABLE_PIN),
  .SLOW_CLOCK_OUT    (SLOW_CLOCK_OUT)
);
